/* verilog/sst_pkg.sv */
// shared constants and types for the spreader and strobe timing block
`default_nettype none
package sst_pkg;
  // clock period of aclk in picoseconds
  localparam int CLK_PERIOD_PS = 25000;
  // register indices; byte address is four times the index
  localparam logic [5:0] IDX_STRENGTH = 6'h0a;
  localparam logic [5:0] IDX_ENABLE = 6'h0b;
  localparam logic [5:0] IDX_STATUS = 6'h0c;
  localparam logic [5:0] IDX_TIMING = 6'h19;
  // field positions
  localparam int STRENGTH_BIT = 7;
  localparam int ENABLE_BIT = 7;
  localparam int TIM_WE0_BIT = 0;
  localparam int TIM_WE1_BIT = 1;
  localparam int TIM_OE0_BIT = 2;
  localparam int TIM_OE1_BIT = 3;
  localparam int STAT_ACTIVE_BIT = 0;
  localparam int STAT_DRAIN_BIT = 1;
  localparam int STAT_STRONG_BIT = 2;
  localparam int STAT_OFFSET_LSB = 8;
  // reset values
  localparam logic STRENGTH_RST = 1'b0;
  localparam logic ENABLE_RST = 1'b0;
  localparam logic [3:0] TIMING_RST = 4'h0;
  // disable drain time in system clocks
  localparam logic [9:0] DISABLE_CLKS = 10'd500;
  // edge error bounds and the size of one modulation step
  localparam int ERR_NORMAL_NS = 35;
  localparam int ERR_STRONG_NS = 70;
  localparam int STEP_NS = 5;
  localparam logic signed [5:0] LIMIT_NORMAL = 6'(ERR_NORMAL_NS / STEP_NS);
  localparam logic signed [5:0] LIMIT_STRONG = 6'(ERR_STRONG_NS / STEP_NS);
  // clocks between two modulation steps
  localparam logic [2:0] MOD_INTERVAL = 3'd4;
  // clock adjust codes
  localparam logic [1:0] ADJ_NONE = 2'b00;
  localparam logic [1:0] ADJ_SHORTEN = 2'b01;
  localparam logic [1:0] ADJ_LENGTHEN = 2'b10;
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  typedef enum logic [1:0] {SP_OFF = 2'b00, SP_ON = 2'b01, SP_DRAIN = 2'b10} sst_spread_e;
  typedef enum logic [1:0] {MEM_IDLE = 2'b00, MEM_T1 = 2'b01, MEM_T2 = 2'b10} sst_mem_e;
endpackage
`default_nettype wire

/* verilog/sst_strobe_gen.sv */
// one memory strobe shaped at half-clock resolution
`timescale 1ns/1ps
`default_nettype none
module sst_strobe_gen
  import sst_pkg::*;
#(
  parameter bit IS_WRITE = 1'b0
) (
  input wire logic aclk, // system clock
  input wire logic aresetn, // synchronous reset, active low
  input wire logic start, // access taken this cycle, prep slot
  input wire logic extended, // extended timing select
  output logic [1:0] strobe_n // [1] high half, [0] low half, active low
);
  logic t1_q, t1_d, t2_q, t2_d, ext_q, ext_d;
  logic [1:0] wave_q, wave_d;
  logic [1:0] act;

  // slot tracking; timing choice frozen at start so a cycle never mixes modes
  always_comb begin
    t1_d = start;
    t2_d = t1_q;
    ext_d = start ? extended : ext_q;
    act = 2'b00;
    if (IS_WRITE) begin
      act[1] = t1_q | t2_q;
      act[0] = t1_q | (start & extended);
    end else begin
      act[1] = t2_q;
      act[0] = t2_q | (t1_q & ext_q);
    end
    wave_d = ~act;
  end

  // registered so the strobe pins carry no decode glitches
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      t1_q <= 1'b0;
      t2_q <= 1'b0;
      ext_q <= 1'b0;
      wave_q <= 2'b11;
    end else begin
      t1_q <= t1_d;
      t2_q <= t2_d;
      ext_q <= ext_d;
      wave_q <= wave_d;
    end
  end

  assign strobe_n = wave_q;
endmodule // sst_strobe_gen
`default_nettype wire

/* verilog/sst_top.sv */
// spreader control, strobe timing and axi4-lite register slave
//
// What this block does
// - spreader has three settings: off, normal spreading, strong spreading
// - strength register bit 7: zero normal, one strong
// - enable register bit 7 set turns spreading on, cleared requests off
// - strength is sampled only when spreading becomes enabled
// - modulation may continue up to 500 clocks after disable
// - bits 6 to 0 of both spreader registers are reserved
// - feedback bounds edge error to 35 ns normal, 70 ns strong
// - only one of the two clocks of a memory cycle is shortened
// - timing register bits 7 to 4 are reserved
// - timing bit 3: second read strobe normal or half clock earlier
// - timing bit 2: first read strobe normal or half clock earlier
// - timing bit 1: second write strobe 1.5 clocks or 2 clocks
// - timing bit 0: first write strobe 1.5 clocks or 2 clocks
`timescale 1ns/1ps
`default_nettype none
module sst_top
  import sst_pkg::*;
(
  input wire logic aclk, // system clock, 40 mhz
  input wire logic aresetn, // synchronous reset, active low
  input wire logic [7:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write byte enables
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [7:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  input wire logic mem_req, // memory access request
  input wire logic mem_write, // access is a write
  input wire logic mem_bank, // 0 first strobe pair, 1 second
  output logic mem_ready, // request taken when high with mem_req
  output logic [1:0] first_read_strobe_n, // halves of read strobe 0
  output logic [1:0] second_read_strobe_n, // halves of read strobe 1
  output logic [1:0] first_write_strobe_n, // halves of write strobe 0
  output logic [1:0] second_write_strobe_n, // halves of write strobe 1
  output logic spread_active, // clock is being modulated
  output logic spread_strong, // strong setting in force
  output logic [1:0] clk_adjust, // per-cycle shorten or lengthen
  output logic signed [5:0] time_offset // accumulated edge offset in steps
);
  // register file state
  logic strength_q, strength_d, enable_q, enable_d;
  logic [3:0] timing_q, timing_d;
  // axi write side
  logic aw_hold_q, aw_hold_d, w_hold_q, w_hold_d, bvalid_q, bvalid_d;
  logic [5:0] awidx_q, awidx_d;
  logic [7:0] wbyte_q, wbyte_d;
  logic wlane_q, wlane_d;
  logic [1:0] bresp_q, bresp_d;
  // axi read side
  logic rvalid_q, rvalid_d;
  logic [31:0] rdata_q, rdata_d;
  logic [1:0] rresp_q, rresp_d;
  logic [31:0] status_word;
  logic do_write;
  // spreader state
  sst_spread_e sp_q, sp_d;
  logic strong_q, strong_d;
  logic [9:0] drain_q, drain_d;
  logic [2:0] mod_cnt_q, mod_cnt_d;
  logic dir_q, dir_d;
  logic signed [5:0] offset_q, offset_d;
  logic signed [5:0] limit;
  logic [1:0] adj_q, adj_d;
  // memory cycle state
  sst_mem_e mem_q, mem_d;
  logic take;
  logic [3:0] start_vec;
  logic [1:0] strb_n [4];

  assign s_axi_awready = !aw_hold_q && !bvalid_q;
  assign s_axi_wready = !w_hold_q && !bvalid_q;
  assign s_axi_arready = !rvalid_q;
  assign do_write = aw_hold_q && w_hold_q && !bvalid_q;

  // status word shows the spreader's live state
  assign status_word = {18'h0, offset_q, 5'h0, strong_q, (sp_q == SP_DRAIN), (sp_q != SP_OFF)};

  // write channel: address and data captured in either order, applied together
  always_comb begin
    aw_hold_d = aw_hold_q;
    awidx_d = awidx_q;
    w_hold_d = w_hold_q;
    wbyte_d = wbyte_q;
    wlane_d = wlane_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    strength_d = strength_q;
    enable_d = enable_q;
    timing_d = timing_q;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_hold_d = 1'b1;
      awidx_d = s_axi_awaddr[7:2];
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_hold_d = 1'b1;
      wbyte_d = s_axi_wdata[7:0];
      wlane_d = s_axi_wstrb[0];
    end
    if (do_write) begin
      aw_hold_d = 1'b0;
      w_hold_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = RESP_OKAY;
      unique case (awidx_q)
        // the spreader registers keep only bit 7 and the timing register keeps bits 3 to 0; the reserved bits are dropped
        IDX_STRENGTH: if (wlane_q) strength_d = wbyte_q[STRENGTH_BIT];
        IDX_ENABLE: if (wlane_q) enable_d = wbyte_q[ENABLE_BIT];
        IDX_TIMING: if (wlane_q) timing_d = wbyte_q[3:0];
        IDX_STATUS: bresp_d = RESP_OKAY;
        default: bresp_d = RESP_SLVERR;
      endcase
    end
    if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
  end

  // read channel: one cycle from address to data
  always_comb begin
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_d = 1'b1;
      rresp_d = RESP_OKAY;
      unique case (s_axi_araddr[7:2])
        IDX_STRENGTH: rdata_d = {24'h0, strength_q, 7'h00};
        IDX_ENABLE: rdata_d = {24'h0, enable_q, 7'h00};
        IDX_TIMING: rdata_d = {28'h0, timing_q};
        IDX_STATUS: rdata_d = status_word;
        default: begin
          rdata_d = 32'h0;
          rresp_d = RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      awidx_q <= 6'h00;
      w_hold_q <= 1'b0;
      wbyte_q <= 8'h00;
      wlane_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0;
      rresp_q <= RESP_OKAY;
      strength_q <= STRENGTH_RST;
      enable_q <= ENABLE_RST;
      timing_q <= TIMING_RST;
    end else begin
      aw_hold_q <= aw_hold_d;
      awidx_q <= awidx_d;
      w_hold_q <= w_hold_d;
      wbyte_q <= wbyte_d;
      wlane_q <= wlane_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
      strength_q <= strength_d;
      enable_q <= enable_d;
      timing_q <= timing_d;
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  // memory cycle: prep slot at take, then the two clocks t1 and t2
  assign mem_ready = (mem_q == MEM_IDLE);
  assign take = mem_ready && mem_req;
  always_comb begin
    mem_d = mem_q;
    unique case (mem_q)
      MEM_IDLE: if (take) mem_d = MEM_T1;
      MEM_T1: mem_d = MEM_T2;
      MEM_T2: mem_d = MEM_IDLE;
      default: mem_d = MEM_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mem_q <= MEM_IDLE;
    end else begin
      mem_q <= mem_d;
    end
  end

  // strobe starts, index order matches the timing register bits
  assign start_vec[TIM_WE0_BIT] = take && mem_write && !mem_bank;
  assign start_vec[TIM_WE1_BIT] = take && mem_write && mem_bank;
  assign start_vec[TIM_OE0_BIT] = take && !mem_write && !mem_bank;
  assign start_vec[TIM_OE1_BIT] = take && !mem_write && mem_bank;

  // each of the four strobes gets its own shaper; write strobes sit on the low indices
  for (genvar i = 0; i < 4; i++) begin : g_strobe
    sst_strobe_gen #(
      .IS_WRITE(i < 2)
    ) u_strobe (
      .aclk(aclk),
      .aresetn(aresetn),
      .start(start_vec[i]),
      .extended(timing_q[i]),
      .strobe_n(strb_n[i])
    );
  end

  assign first_write_strobe_n = strb_n[TIM_WE0_BIT];
  assign second_write_strobe_n = strb_n[TIM_WE1_BIT];
  assign first_read_strobe_n = strb_n[TIM_OE0_BIT];
  assign second_read_strobe_n = strb_n[TIM_OE1_BIT];

  // spreader control and modulation model
  assign limit = strong_q ? LIMIT_STRONG : LIMIT_NORMAL;
  always_comb begin
    sp_d = sp_q;
    strong_d = strong_q;
    drain_d = drain_q;
    mod_cnt_d = mod_cnt_q;
    dir_d = dir_q;
    offset_d = offset_q;
    adj_d = ADJ_NONE;
    unique case (sp_q)
      SP_OFF: begin
        offset_d = 6'sd0;
        dir_d = 1'b1;
        mod_cnt_d = 3'd0;
        if (enable_q) begin
          sp_d = SP_ON;
          strong_d = strength_q;
        end
      end
      SP_ON: begin
        if (!enable_q) begin
          sp_d = SP_DRAIN;
          drain_d = 10'd0;
        end
      end
      SP_DRAIN: begin
        // re-enabling is held off until the drain ends, then sampled fresh
        if (drain_q == DISABLE_CLKS - 10'd1) begin
          sp_d = SP_OFF;
        end else begin
          drain_d = drain_q + 10'd1;
        end
      end
      default: sp_d = SP_OFF;
    endcase
    // modulation steps while on or draining
    if (sp_q != SP_OFF) begin
      if (mod_cnt_q != MOD_INTERVAL - 3'd1) begin
        mod_cnt_d = mod_cnt_q + 3'd1;
      end else if (dir_q) begin
        mod_cnt_d = 3'd0;
        adj_d = ADJ_LENGTHEN;
        offset_d = offset_q + 6'sd1;
        if (offset_q + 6'sd1 >= limit) dir_d = 1'b0;
      end else if (mem_q != MEM_T2) begin
        // a shortened step is held while mem_q is t2, so the clock after t2 is never shortened
        mod_cnt_d = 3'd0;
        adj_d = ADJ_SHORTEN;
        offset_d = offset_q - 6'sd1;
        if (offset_q - 6'sd1 <= -limit) dir_d = 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sp_q <= SP_OFF;
      strong_q <= 1'b0;
      drain_q <= 10'd0;
      mod_cnt_q <= 3'd0;
      dir_q <= 1'b1;
      offset_q <= 6'sd0;
      adj_q <= ADJ_NONE;
    end else begin
      sp_q <= sp_d;
      strong_q <= strong_d;
      drain_q <= drain_d;
      mod_cnt_q <= mod_cnt_d;
      dir_q <= dir_d;
      offset_q <= offset_d;
      adj_q <= adj_d;
    end
  end

  assign spread_active = (sp_q != SP_OFF);
  assign spread_strong = strong_q;
  assign clk_adjust = adj_q;
  assign time_offset = offset_q;
endmodule // sst_top
`default_nettype wire

/* sim/sst_chk.sv */
// checker on strobe shape, memory cycle and spreader outputs
`timescale 1ns/1ps
`default_nettype none
module sst_chk
  import sst_pkg::*;
(
  input wire logic aclk, // clock
  input wire logic aresetn, // reset
  input wire logic mem_req, // access req
  input wire logic mem_write, // write kind
  input wire logic mem_bank, // pair
  input wire logic mem_ready, // fsm idle
  input wire logic [1:0] first_write_strobe_n, // write 0
  input wire logic [1:0] second_read_strobe_n, // read 1
  input wire logic spread_active, // spreading
  input wire logic spread_strong, // strong
  input wire logic [1:0] clk_adjust, // step code
  input wire logic signed [5:0] time_offset // offset
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [9:0] run_q;
  logic [9:0] run_d;
  // length of the active stretch, saturating so it never wraps
  always_comb begin
    run_d = spread_active ? run_q + 10'(run_q != 10'h3ff) : 10'h0;
  end
  always_ff @(posedge aclk) begin
    run_q <= aresetn ? run_d : 10'h0;
  end
  property p_wr0;
    mem_req && mem_ready && mem_write && !mem_bank |-> ##2 first_write_strobe_n == 2'b00
      ##1 first_write_strobe_n == 2'b01 ##1 first_write_strobe_n == 2'b11;
  endproperty
  a_wr0: assert property (p_wr0) else $error("write strobe shape wrong");
  property p_rd1;
    mem_req && mem_ready && !mem_write && mem_bank |-> ##3 second_read_strobe_n == 2'b00
      ##1 second_read_strobe_n == 2'b11;
  endproperty
  a_rd1: assert property (p_rd1) else $error("read strobe shape wrong");
  property p_cyc;
    mem_req && mem_ready |=> !mem_ready ##1 !mem_ready ##1 mem_ready;
  endproperty
  a_cyc: assert property (p_cyc) else $error("memory cycle not two clocks");
  property p_off;
    !spread_active ##1 !spread_active |-> time_offset == 6'sd0 && clk_adjust == ADJ_NONE;
  endproperty
  a_off: assert property (p_off) else $error("modulation while off");
  property p_lim;
    spread_active |-> time_offset <= (spread_strong ? LIMIT_STRONG : LIMIT_NORMAL)
      && time_offset >= -(spread_strong ? LIMIT_STRONG : LIMIT_NORMAL);
  endproperty
  a_lim: assert property (p_lim) else $error("edge offset out of bound");
  property p_strg;
    spread_active && $past(spread_active) |-> $stable(spread_strong);
  endproperty
  a_strg: assert property (p_strg) else $error("strength changed while on");
  property p_drn;
    $fell(spread_active) |-> run_q >= 10'd499;
  endproperty
  a_drn: assert property (p_drn) else $error("drain ended early");
  property p_adj;
    clk_adjust != ADJ_NONE |=> clk_adjust == ADJ_NONE;
  endproperty
  a_adj: assert property (p_adj) else $error("adjust code not a pulse");
  property p_shrt;
    mem_req && mem_ready |=> not (clk_adjust == ADJ_SHORTEN ##1 clk_adjust == ADJ_SHORTEN);
  endproperty
  a_shrt: assert property (p_shrt) else $error("both clocks of a memory cycle shortened");
endmodule // sst_chk
bind sst_top sst_chk u_sst_chk (.*);
`default_nettype wire

/* sim/sst_mem_model.sv */
// passive static memory: measures each strobe pulse in half clocks
`timescale 1ns/1ps
`default_nettype none
module sst_mem_model (
  input wire logic aclk, // clock
  input wire logic aresetn, // reset
  input wire logic [7:0] strobes_n, // four strobe pairs
  output logic [2:0] halves [4], // low halves of last pulse
  output logic [3:0] pulses [4] // finished pulses, wraps
);
  logic [2:0] run [4];
  // sampled on the falling edge, away from the strobe register updates
  always @(negedge aclk) begin
    for (int i = 0; i < 4; i++) begin
      if (!aresetn) begin
        run[i] <= 3'h0;
        halves[i] <= 3'h0;
        pulses[i] <= 4'h0;
      end else if (strobes_n[2*i+:2] == 2'b11) begin
        // count pulses so a missing strobe cannot hide behind a stale length
        if (run[i] != 3'h0) begin
          halves[i] <= run[i];
          pulses[i] <= pulses[i] + 4'h1;
        end
        run[i] <= 3'h0;
      end else begin
        run[i] <= run[i] + 3'(!strobes_n[2*i+1]) + 3'(!strobes_n[2*i]);
      end
    end
  end
endmodule // sst_mem_model
`default_nettype wire

/* sim/tb_top.sv */
// testbench: register bus, strobe shapes and spreader sequence
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import sst_pkg::*;
;
  logic aclk = 1'b0;
  logic aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, mem_req, mem_write, mem_bank, mem_ready;
  logic spread_active, spread_strong;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, clk_adjust;
  logic [1:0] first_read_strobe_n, second_read_strobe_n, first_write_strobe_n, second_write_strobe_n;
  logic signed [5:0] time_offset;
  logic [2:0] halves [4];
  logic [3:0] pulses [4];
  int err_count = 0;
  int compares = 0;
  sst_top u_sst_top (.*);
  sst_mem_model u_sst_mem_model (.aclk(aclk), .aresetn(aresetn), .halves(halves), .pulses(pulses),
    .strobes_n({second_write_strobe_n, first_write_strobe_n, second_read_strobe_n, first_read_strobe_n}));
  // 40 mhz clock
  initial forever #12.5 aclk = ~aclk;
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic summarize();
    if (err_count == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic tmo(input bit ok);
    if (!ok) begin
      chk("timeout", 32'h0, 32'h1);
      summarize();
    end
  endtask
  // handshakes decided at the falling edge so no race with the slave
  task automatic wrc(input logic [7:0] a, input logic [7:0] d, input logic [1:0] re);
    bit aw, w, b;
    logic [1:0] r;
    b = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    for (int n = 0; n < 50 && !b; n++) begin
      @(negedge aclk);
      aw = s_axi_awvalid && s_axi_awready;
      w = s_axi_wvalid && s_axi_wready;
      b = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge aclk);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    tmo(b);
    chk("bresp", {30'h0, re}, {30'h0, r});
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    bit ar, v;
    logic [1:0] r;
    v = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'b11;
    for (int n = 0; n < 50 && !v; n++) begin
      @(negedge aclk);
      ar = s_axi_arvalid && s_axi_arready;
      v = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
      if (ar) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
    tmo(v);
    chk("rresp", {30'h0, (a == 8'h10) ? RESP_SLVERR : RESP_OKAY}, {30'h0, r});
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    rd(a, d);
    chk("rdata", e, d);
  endtask
  // pulse length in half clocks: write 1.5 or 2 clocks, read 1 or 1.5
  function automatic logic [2:0] halves_exp(input logic w, input logic ext);
    return w ? 3'(3 + ext) : 3'(2 + ext);
  endfunction
  task automatic acc(input logic w, input logic b, input logic [3:0] tim);
    bit t;
    logic [3:0] p0;
    t = 0;
    p0 = pulses[{w, b}];
    @(posedge aclk);
    {mem_req, mem_write, mem_bank} <= {1'b1, w, b};
    for (int n = 0; n < 20 && !t; n++) begin
      @(negedge aclk);
      t = mem_ready;
      @(posedge aclk);
      if (t) mem_req <= 1'b0;
    end
    tmo(t);
    repeat (6) @(negedge aclk);
    chk("halves", {29'h0, halves_exp(w, tim[{!w, b}])}, {29'h0, halves[{w, b}]});
    chk("pulses", {28'h0, 4'(p0 + 4'h1)}, {28'h0, pulses[{w, b}]});
  endtask
  task automatic wact();
    for (int n = 0; n < 10 && !spread_active; n++) @(negedge aclk);
    tmo(spread_active);
  endtask
  // main sequence
  initial begin
    logic [31:0] v;
    int n;
    logic signed [5:0] off;
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, mem_req, mem_write, mem_bank} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    void'($urandom(32'h3d8c));
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    rdc(8'h28, 32'h0);
    rdc(8'h2c, 32'h0);
    rdc(8'h64, 32'h0);
    rdc(8'h10, 32'h0);
    wrc(8'h64, 8'hff, RESP_OKAY);
    rdc(8'h64, 32'h0f);
    // lane 0 disabled: the write must leave the register alone
    s_axi_wstrb <= 4'he;
    wrc(8'h64, 8'h00, RESP_OKAY);
    rdc(8'h64, 32'h0f);
    s_axi_wstrb <= 4'hf;
    wrc(8'h10, 8'h55, RESP_SLVERR);
    rdc(8'h64, 32'h0f);
    wrc(8'h28, 8'h7f, RESP_OKAY);
    rdc(8'h28, 32'h0);
    wrc(8'h2c, 8'h7f, RESP_OKAY);
    repeat (8) @(negedge aclk);
    chk("active", 32'h0, spread_active);
    wrc(8'h28, 8'h80, RESP_OKAY);
    wrc(8'h2c, 8'h80 | 8'($urandom_range(127)), RESP_OKAY);
    wact();
    chk("strong", 32'h1, spread_strong);
    wrc(8'h28, 8'h00, RESP_OKAY);
    // random strobe timings and accesses while the clock is modulated
    repeat (24) begin
      v = $urandom;
      wrc(8'h64, {4'h0, v[3:0]}, RESP_OKAY);
      acc(v[4], v[5], v[3:0]);
    end
    chk("strong", 32'h1, spread_strong);
    rd(8'h30, v);
    chk("status", (32'h1 << STAT_ACTIVE_BIT) | (32'h1 << STAT_STRONG_BIT), {29'h0, v[2:0]});
    // strong setting is in force here, so the wider bound applies
    off = v[STAT_OFFSET_LSB +: 6];
    chk("offset", 32'h1, {31'h0, off <= LIMIT_STRONG && off >= -LIMIT_STRONG});
    // full reconfigure: clear, wait out the drain, set strength, enable
    wrc(8'h2c, 8'h00, RESP_OKAY);
    for (n = 0; n < 600 && spread_active; n++) @(negedge aclk);
    chk("drain", 32'h1, {31'h0, n >= 490 && n <= 501});
    v = $urandom;
    wrc(8'h28, {v[0], 7'h00}, RESP_OKAY);
    wrc(8'h2c, 8'h80, RESP_OKAY);
    wact();
    chk("strong", {31'h0, v[0]}, {31'h0, spread_strong});
    summarize();
  end
endmodule // tb_top
`default_nettype wire
